// *** design/lpic_pkg.sv ***
// constants for the cascaded legacy interrupt controller pair
// assumes an 8-bit register port at 16-bit i/o addresses
//
// How it works
// - fully nested order ranks input 0 highest and 7 lowest; acknowledge marks winner
// - a set in-service bit holds back equal and lower levels
// - in-service bit holds until end command, or second acknowledge in auto mode
// - special fully nested master still hears higher requests from a serviced slave
// - plain nested master blocks the cascade input while the slave is served
// - automatic rotation puts a serviced level at the bottom of eight
// - rotate command word: rotate on plain end, or rotate in automatic mode
// - set-priority command makes the coded level bottom, next one top
// - rotate on specific end clears the coded level and puts it bottom
// - poll command turns next read into acknowledge; requests freeze meanwhile
// - poll byte carries pending flag in bit 7 and level in bits 2:0
// - slave hangs on master input 2 and answers when bus shows 010b
// - controller-wide trigger bit of the first init word is ignored
// - trigger bit 0 latches only on a rising input
// - trigger bit 1 latches whenever the input is high
// - a request gone before the first acknowledge yields the level 7 vector
// - plain end clears the top in-service bit, specific end the named one
// - in special mask mode a plain end skips masked in-service bits
// - automatic end mode, master only, ends at the last acknowledge
// - vector is the base bits 7:3 with the level code below
// - request latch ignores masking; masked inputs never raise the output
package lpic_pkg;
	localparam logic [15:0] LPIC_M_CMD_ADDR   = 16'h0020;
	localparam logic [15:0] LPIC_M_DATA_ADDR  = 16'h0021;
	localparam logic [15:0] LPIC_S_CMD_ADDR   = 16'h00a0;
	localparam logic [15:0] LPIC_S_DATA_ADDR  = 16'h00a1;
	localparam logic [15:0] LPIC_M_TRIG_ADDR  = 16'h04d0;
	localparam logic [15:0] LPIC_S_TRIG_ADDR  = 16'h04d1;
	// trigger bits that software may change; the rest stay edge, except master input 2, which is always level
	localparam logic [7:0]  LPIC_M_TRIG_WMASK = 8'hf8;
	localparam logic [7:0]  LPIC_S_TRIG_WMASK = 8'hde;
	// command byte decode positions
	localparam int LPIC_INIT_BIT   = 4;
	localparam int LPIC_POLL_READSEL_COMMAND_WORD_BIT   = 3;
	localparam int LPIC_ROT_BIT    = 7;
	localparam int LPIC_SEL_BIT    = 6;
	localparam int LPIC_EOI_BIT    = 5;
	localparam int LPIC_ESMM_BIT   = 6;
	localparam int LPIC_SMM_BIT    = 5;
	localparam int LPIC_POLL_BIT   = 2;
	localparam int LPIC_RR_BIT     = 1;
	localparam int LPIC_RIS_BIT    = 0;
	localparam int LPIC_AUTO_END_OF_INTERRUPT_BIT   = 1;
	localparam int LPIC_SFNM_BIT   = 4;
	localparam int LPIC_FLAG_BIT   = 7;
	localparam logic [2:0] LPIC_CASCADE_ID = 3'h2;
	localparam logic [2:0] LPIC_DEF_LEVEL  = 3'h7;
	localparam logic [2:0] LPIC_RST_BOTTOM = 3'h7;
	localparam logic [1:0] LPIC_STEP_LAST  = 2'h3;
	typedef enum logic [1:0]
	{
		LPIC_IDLE = 2'b00,
		LPIC_ACK1 = 2'b01,
		LPIC_ACK2 = 2'b10
	} lpic_ack_st_t;
endpackage

// *** design/lpic_top.sv ***
// master and slave interrupt controllers with ack sequencing and poll
// assumes one-cycle read/write strobes and an ack request pulse per cycle
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
module lpic_top
	import lpic_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	input  wire logic [15:0] addr,
	input  wire logic [7:0]  wr_data,
	input  wire logic        wr_en,
	input  wire logic        rd_en,
	output logic      [7:0]  rd_data,
	input  wire logic [15:0] irq_in,
	input  wire logic        ack_req,
	output logic             processor_irq_out,
	output logic             internal_ack_pulse,
	output logic      [2:0]  cascade_code,
	output logic      [7:0]  vector_data,
	output logic             vector_valid
);

	// walk the eight levels from just above the bottom one;
	// stop at the first in-service level unless cascade passes it
	function automatic logic [3:0] lpic_resolve(
		input logic [7:0] pend,
		input logic [7:0] blk,
		input logic [2:0] bot,
		input logic       sfnm
	);
		logic [2:0] idx;
		logic       done;
		logic [3:0] res;
		res = 4'h0;
		done = 1'b0;
		idx = bot;
		for (int k = 0; k < 8; k++)
		begin
			idx = idx + 3'h1;
			if (!done && pend[idx] &&
				(!blk[idx] || (sfnm && idx == LPIC_CASCADE_ID)))
			begin
				res = {1'b1, idx};
				done = 1'b1;
			end
			if (blk[idx])
				done = 1'b1;
		end
		return res;
	endfunction

	lpic_ack_st_t st_r;
	lpic_ack_st_t st_nxt;
	logic [7:0]   irr_r  [2];
	logic [7:0]   isr_r  [2];
	logic [7:0]   imr_r  [2];
	logic [7:0]   prev_r [2];
	logic [7:0]   trig_r [2];
	logic [4:0]   vbase_r [2];
	logic [2:0]   bot_r  [2];
	logic [1:0]   step_r [2];
	logic         auto_end_of_interrupt_r [2];
	logic         sfnm_r [2];
	logic         smm_r  [2];
	logic         rsel_r [2];
	logic         poll_r [2];
	logic         rota_r [2];
	logic         found_w [2];
	logic [2:0]   code_w [2];
	logic [7:0]   rdv_w  [2];
	logic [7:0]   rd_data_r;
	logic [7:0]   rd_nxt;
	logic         irq_r;
	logic         ackp_r;
	logic [2:0]   casc_r;
	logic [2:0]   mcode_r;
	logic [2:0]   scode_r;
	logic [7:0]   vec_r;
	logic         vval_r;
	logic         m_take;
	logic         s_take;
	logic         st_idle;

	assign st_idle = st_r == LPIC_IDLE;
	// winner chosen at the first pulse; slave takes only if routed through 2
	assign m_take = st_r == LPIC_ACK1 && found_w[0];
	assign s_take = m_take && code_w[0] == LPIC_CASCADE_ID &&
		found_w[1];

	for (genvar c = 0; c < 2; c++)
	begin : g_ctl
		localparam logic [15:0] CMD_A  = c == 0 ? LPIC_M_CMD_ADDR :
			LPIC_S_CMD_ADDR;
		localparam logic [15:0] DATA_A = c == 0 ? LPIC_M_DATA_ADDR :
			LPIC_S_DATA_ADDR;
		localparam logic [15:0] TRIG_A = c == 0 ? LPIC_M_TRIG_ADDR :
			LPIC_S_TRIG_ADDR;
		localparam logic [7:0]  WMASK  = c == 0 ? LPIC_M_TRIG_WMASK :
			LPIC_S_TRIG_WMASK;
		localparam logic [7:0]  CASC_LVL = c == 0 ? 8'h04 : 8'h00;

		logic       cmd_wr;
		logic       data_wr;
		logic       init_word_first;
		logic       rotate_eoi_command_word;
		logic       poll_readsel_command_word;
		logic       ns_eoi;
		logic       sp_eoi;
		logic       auto_end_of_interrupt_clr;
		logic       poll_rd;
		logic       take;
		logic [2:0] lvl;
		logic [7:0] samp;
		logic [7:0] trig_eff;
		logic [7:0] hit;
		logic [7:0] pend;
		logic [7:0] blk;
		logic [3:0] res;
		logic [3:0] hi;
		logic [7:0] set_vec;
		logic [7:0] clr_vec;
		logic [7:0] irr_nxt;
		logic [7:0] isr_nxt;
		logic [7:0] prev_nxt;
		logic [2:0] bot_nxt;

		// command decode; bit 3 of the first init word is never looked at
		assign cmd_wr  = wr_en && addr == CMD_A;
		assign data_wr = wr_en && addr == DATA_A;
		assign init_word_first    = cmd_wr && wr_data[LPIC_INIT_BIT];
		assign rotate_eoi_command_word    = cmd_wr && !wr_data[LPIC_INIT_BIT] &&
			!wr_data[LPIC_POLL_READSEL_COMMAND_WORD_BIT];
		assign poll_readsel_command_word    = cmd_wr && !wr_data[LPIC_INIT_BIT] &&
			wr_data[LPIC_POLL_READSEL_COMMAND_WORD_BIT];
		assign lvl     = wr_data[2:0];
		assign ns_eoi  = rotate_eoi_command_word && wr_data[LPIC_EOI_BIT] &&
			!wr_data[LPIC_SEL_BIT];
		assign sp_eoi  = rotate_eoi_command_word && wr_data[LPIC_EOI_BIT] &&
			wr_data[LPIC_SEL_BIT];
		// auto end runs only in the master, at the close of the last pulse
		assign auto_end_of_interrupt_clr = c == 0 && auto_end_of_interrupt_r[c] && st_r == LPIC_ACK2;
		assign poll_rd  = rd_en && addr == CMD_A && poll_r[c];
		assign take     = (c == 0 ? m_take : s_take) ||
			(poll_rd && found_w[c]);

		// master input 2 is the slave's output, always taken as a level
		assign samp = c == 0 ?
			{irq_in[7:3], found_w[1], irq_in[1:0]} : irq_in[15:8];
		assign trig_eff = trig_r[c] | CASC_LVL;
		assign hit = (trig_eff & samp) | (~trig_eff & samp & ~prev_r[c]);

		// priority resolution; special mask mode lifts in-service blocking
		assign pend = irr_r[c] & ~imr_r[c] &
			~(smm_r[c] ? isr_r[c] : 8'h00);
		assign blk  = smm_r[c] ? 8'h00 : isr_r[c];
		assign res  = lpic_resolve(pend, blk, bot_r[c], sfnm_r[c]);
		assign found_w[c] = res[3];
		assign code_w[c]  = res[2:0];

		// top in-service level, skipping masked ones in special mask mode
		assign hi = lpic_resolve(isr_r[c] & ~(smm_r[c] ? imr_r[c] : 8'h00),
			8'h00, bot_r[c], 1'b0);

		assign set_vec = take ? 8'h01 << code_w[c] : 8'h00;
		assign clr_vec = ((ns_eoi || auto_end_of_interrupt_clr) && hi[3]) ?
			8'h01 << hi[2:0] : sp_eoi ? 8'h01 << lvl : 8'h00;
		// a set in the same cycle as a clear wins
		assign isr_nxt = init_word_first ? 8'h00 : (isr_r[c] & ~clr_vec) | set_vec;

		// frozen while a poll is outstanding; level bits follow the line
		assign irr_nxt = init_word_first ? 8'h00 :
			poll_r[c] ? irr_r[c] & ~set_vec :
			((irr_r[c] & ~trig_eff) | hit) & ~set_vec;
		// after init every edge-triggered input needs a fresh rising edge
		assign prev_nxt = init_word_first ? 8'hff : poll_r[c] ? prev_r[c] : samp;

		assign bot_nxt = init_word_first ? LPIC_RST_BOTTOM :
			(rotate_eoi_command_word && wr_data[LPIC_ROT_BIT] && wr_data[LPIC_SEL_BIT]) ?
			lvl :
			(ns_eoi && wr_data[LPIC_ROT_BIT] && hi[3]) ? hi[2:0] :
			(auto_end_of_interrupt_clr && rota_r[c] && hi[3]) ? hi[2:0] :
			bot_r[c];

		assign rdv_w[c] = addr == CMD_A ? (poll_r[c] ?
			{found_w[c], 4'h0, found_w[c] ? code_w[c] : 3'h0} :
			rsel_r[c] ? isr_r[c] : irr_r[c]) :
			addr == DATA_A ? imr_r[c] :
			addr == TRIG_A ? trig_r[c] : 8'h00;

		// per-controller state
		always_ff @(posedge sys_clk)
		begin
			if (!nrst)
			begin
				irr_r[c]   <= 8'h00;
				isr_r[c]   <= 8'h00;
				imr_r[c]   <= 8'h00;
				prev_r[c]  <= 8'hff;
				trig_r[c]  <= 8'h00;
				vbase_r[c] <= 5'h00;
				bot_r[c]   <= LPIC_RST_BOTTOM;
				step_r[c]  <= 2'h0;
				auto_end_of_interrupt_r[c]  <= 1'b0;
				sfnm_r[c]  <= 1'b0;
				smm_r[c]   <= 1'b0;
				rsel_r[c]  <= 1'b0;
				poll_r[c]  <= 1'b0;
				rota_r[c]  <= 1'b0;
			end
			else
			begin
				irr_r[c]  <= irr_nxt;
				isr_r[c]  <= isr_nxt;
				prev_r[c] <= prev_nxt;
				bot_r[c]  <= bot_nxt;
				if (wr_en && addr == TRIG_A)
					trig_r[c] <= wr_data & WMASK;
				if (init_word_first)
				begin
					imr_r[c]  <= 8'h00;
					step_r[c] <= 2'h1;
					auto_end_of_interrupt_r[c] <= 1'b0;
					sfnm_r[c] <= 1'b0;
					smm_r[c]  <= 1'b0;
					rsel_r[c] <= 1'b0;
					poll_r[c] <= 1'b0;
					rota_r[c] <= 1'b0;
				end
				else if (data_wr && step_r[c] == 2'h0)
					imr_r[c] <= wr_data;
				else if (data_wr)
				begin
					step_r[c] <= step_r[c] == LPIC_STEP_LAST ? 2'h0 :
						step_r[c] + 2'h1;
					if (step_r[c] == 2'h1)
						vbase_r[c] <= wr_data[7:3];
					// auto end and special nesting exist on the master only
					if (step_r[c] == LPIC_STEP_LAST && c == 0)
					begin
						auto_end_of_interrupt_r[c] <= wr_data[LPIC_AUTO_END_OF_INTERRUPT_BIT];
						sfnm_r[c] <= wr_data[LPIC_SFNM_BIT];
					end
				end
				if (poll_readsel_command_word && wr_data[LPIC_ESMM_BIT])
					smm_r[c] <= wr_data[LPIC_SMM_BIT];
				if (poll_readsel_command_word && wr_data[LPIC_RR_BIT])
					rsel_r[c] <= wr_data[LPIC_RIS_BIT];
				if (poll_readsel_command_word)
					poll_r[c] <= wr_data[LPIC_POLL_BIT];
				else if (poll_rd)
					poll_r[c] <= 1'b0;
				if (rotate_eoi_command_word && wr_data[LPIC_ROT_BIT] &&
					!wr_data[LPIC_SEL_BIT] && !wr_data[LPIC_EOI_BIT])
					rota_r[c] <= 1'b1;
				else if (rotate_eoi_command_word && wr_data[7:5] == 3'h0)
					rota_r[c] <= 1'b0;
			end
		end
	end

	// acknowledge sequencer: two internal pulses per processor cycle
	always_comb
	begin
		st_nxt = st_r;
		case (st_r)
			LPIC_IDLE: if (ack_req) st_nxt = LPIC_ACK1;
			LPIC_ACK1: st_nxt = LPIC_ACK2;
			LPIC_ACK2: st_nxt = LPIC_IDLE;
			default:   st_nxt = LPIC_IDLE;
		endcase
	end

	assign rd_nxt = rd_en ? rdv_w[0] | rdv_w[1] : 8'h00;

	// sequencer and output flops
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			st_r      <= LPIC_IDLE;
			rd_data_r <= 8'h00;
			irq_r     <= 1'b0;
			ackp_r    <= 1'b0;
			casc_r    <= 3'h0;
			mcode_r   <= LPIC_DEF_LEVEL;
			scode_r   <= LPIC_DEF_LEVEL;
			vec_r     <= 8'h00;
			vval_r    <= 1'b0;
		end
		else
		begin
			st_r      <= st_nxt;
			rd_data_r <= rd_nxt;
			irq_r     <= found_w[0];
			ackp_r    <= st_nxt != LPIC_IDLE;
			vval_r    <= st_r == LPIC_ACK2;
			if (st_r == LPIC_ACK1)
			begin
				// slave id goes out on the trailing edge of the first pulse
				casc_r  <= found_w[0] ? code_w[0] : 3'h0;
				// no request left means the default level 7 vector
				mcode_r <= found_w[0] ? code_w[0] : LPIC_DEF_LEVEL;
				scode_r <= found_w[1] ? code_w[1] : LPIC_DEF_LEVEL;
			end
			if (st_r == LPIC_ACK2)
				vec_r <= casc_r == LPIC_CASCADE_ID ?
					{vbase_r[1], scode_r} : {vbase_r[0], mcode_r};
		end
	end

	assign rd_data            = rd_data_r;
	assign processor_irq_out  = irq_r;
	assign internal_ack_pulse = ackp_r;
	assign cascade_code       = casc_r;
	assign vector_data        = vec_r;
	assign vector_valid       = vval_r;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);

	ack_seq_a: assert property (st_idle && ack_req |-> ##3 vval_r)
		else $error("vector not delivered three cycles after ack");
	isr_set_a: assert property (m_take && !wr_en |=>
		isr_r[0][$past(code_w[0])])
		else $error("winner in-service bit not set");
	def_vec_a: assert property (st_r == LPIC_ACK1 && !found_w[0] |->
		##2 vval_r && vec_r[2:0] == LPIC_DEF_LEVEL)
		else $error("default level 7 vector missing");
	casc_bus_a: assert property (m_take && code_w[0] == LPIC_CASCADE_ID
		|=> casc_r == LPIC_CASCADE_ID ##1 vval_r && vec_r[7:3] == vbase_r[1])
		else $error("slave did not supply vector");
	poll_hold_a: assert property (poll_r[0] && !rd_en && !wr_en && st_idle
		|=> irr_r[0] == $past(irr_r[0]))
		else $error("requests moved during poll freeze");
	poll_byte_a: assert property (rd_en && addr == LPIC_M_CMD_ADDR &&
		poll_r[0] |=> rd_data_r[7] == $past(found_w[0]) &&
		(!rd_data_r[7] || rd_data_r[2:0] == $past(code_w[0])))
		else $error("poll byte wrong");
	slave_noauto_a: assert property (st_r == LPIC_ACK2 && !wr_en |=>
		isr_r[1] == $past(isr_r[1]))
		else $error("slave in-service changed at last pulse");
	edge_only_a: assert property (!trig_r[0][3] && prev_r[0][3] &&
		irq_in[3] && !irr_r[0][3] && !wr_en |=> !irr_r[0][3])
		else $error("steady high input relatched in edge mode");
	level_hit_a: assert property (trig_r[0][3] && irq_in[3] &&
		!poll_r[0] && st_idle && !wr_en && !rd_en |=> irr_r[0][3])
		else $error("high level not latched");
	nest_block_a: assert property (isr_r[0] == 8'h01 &&
		bot_r[0] == LPIC_RST_BOTTOM && !smm_r[0] |-> ##1 !irq_r)
		else $error("lower level passed a served top level");
	spec_eoi_a: assert property (wr_en && addr == LPIC_M_CMD_ADDR &&
		wr_data[7:3] == 5'h0c && st_r != LPIC_ACK1 |=>
		!isr_r[0][$past(wr_data[2:0])])
		else $error("specific end did not clear level");

	// pulse length, auto end, priority and poll side effects
	ack_pulse_a: assert property (st_idle && ack_req |=>
		ackp_r ##1 ackp_r ##1 !ackp_r)
		else $error("acknowledge pulse not two cycles long");
	auto_end_of_interrupt_clear_a: assert property (auto_end_of_interrupt_r[0] && m_take && !wr_en &&
		isr_r[0] == 8'h00 ##1 !rd_en |=> isr_r[0] == 8'h00)
		else $error("auto end left an in-service bit set");
	set_prio_a: assert property (wr_en &&
		addr == LPIC_M_CMD_ADDR && wr_data[7:6] == 2'h3 &&
		wr_data[4:3] == 2'h0 |=> bot_r[0] == $past(wr_data[2:0]))
		else $error("set-priority level not made bottom");
	poll_take_a: assert property (rd_en && poll_r[0] &&
		addr == LPIC_M_CMD_ADDR && found_w[0] && !wr_en |=>
		isr_r[0][$past(code_w[0])] && !poll_r[0])
		else $error("poll read did not acknowledge the winner");
	casc_lock_a: assert property (!sfnm_r[0] && !smm_r[0] &&
		isr_r[0][LPIC_CASCADE_ID] |-> !found_w[0] ||
		code_w[0] != LPIC_CASCADE_ID)
		else $error("served cascade input passed in plain nesting");
endmodule

// *** testbench/lpic_cpu.sv ***
// processor-side model: runs acknowledge cycles and collects the vector
// assumes the controller raises vector_valid a few cycles after ack_req
module lpic_cpu
(
	input  wire logic       sys_clk,
	input  wire logic       vector_valid,
	input  wire logic [7:0] vector_data,
	output logic            ack_req
);
	timeunit 1ns;
	timeprecision 1ns;

	initial ack_req = 1'b0;

	// one acknowledge cycle; dly > 0 models a slow processor
	// the wait is bounded so a dead sequencer cannot hang the run
	task automatic ack(input int dly, output logic [7:0] vec,
		output logic ok);
		int n;
		n = 0;
		@(posedge sys_clk);
		repeat (dly) @(posedge sys_clk);
		ack_req <= 1'b1;
		@(posedge sys_clk);
		ack_req <= 1'b0;
		while (vector_valid !== 1'b1 && n < 8)
		begin
			@(posedge sys_clk);
			n++;
		end
		vec = vector_data;
		ok = (n < 8);
	endtask
endmodule

// *** testbench/legacy_pic_operating_modes_tb.sv ***
// self-checking bench for the cascaded interrupt controller pair
// assumes lpic_cpu as processor model and the register map of lpic_pkg
module legacy_pic_operating_modes_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import lpic_pkg::*;

	logic        sys_clk;
	logic        nrst;
	logic [15:0] addr;
	logic [7:0]  wr_data;
	logic        wr_en;
	logic        rd_en;
	logic [7:0]  rd_data;
	logic [15:0] irq_in;
	logic        ack_req;
	logic        processor_irq_out;
	logic        internal_ack_pulse;
	logic [2:0]  cascade_code;
	logic [7:0]  vector_data;
	logic        vector_valid;
	logic [7:0]  d;
	int          n_errors = 0;
	int          num_checks = 0;
	int          n_pulse = 0;
	localparam logic [15:0] MC = LPIC_M_CMD_ADDR;
	localparam logic [15:0] SC = LPIC_S_CMD_ADDR;

`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
$display("mismatch %0t got %h exp %h", $time, g, e); end end

	lpic_top i_dut (.sys_clk(sys_clk), .nrst(nrst), .addr(addr),
		.wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
		.irq_in(irq_in), .ack_req(ack_req),
		.processor_irq_out(processor_irq_out),
		.internal_ack_pulse(internal_ack_pulse),
		.cascade_code(cascade_code), .vector_data(vector_data),
		.vector_valid(vector_valid));

	lpic_cpu i_cpu (.sys_clk(sys_clk), .vector_valid(vector_valid),
		.vector_data(vector_data), .ack_req(ack_req));

	// count cycles with the internal acknowledge pulse high
	always @(posedge sys_clk)
		if (internal_ack_pulse === 1'b1)
			n_pulse <= n_pulse + 1;

	// clock runs from time zero
	initial
	begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	task automatic stop_test();
		if (n_errors == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// bus cycles: one-cycle strobes launched just after an edge
	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		addr <= a;
		wr_data <= v;
		wr_en <= 1'b1;
		@(posedge sys_clk);
		wr_en <= 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, output logic [7:0] v);
		@(posedge sys_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge sys_clk);
		rd_en <= 1'b0;
		#1 v = rd_data;
	endtask

	task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
		rd(a, d);
		`CHK(d, e)
	endtask

	// select status source with a poll/read word, then read it back
	task automatic st(input logic [15:0] a, input logic [7:0] sel,
		input logic [7:0] e);
		wr(a, sel);
		rdchk(a, e);
	endtask

	task automatic init(input logic [15:0] a, input logic [7:0] w1,
		input logic [7:0] base, input logic [7:0] w4);
		wr(a, w1);
		wr(a + 16'h1, base);
		wr(a + 16'h1, a[7] ? 8'h02 : 8'h04);
		wr(a + 16'h1, w4);
	endtask

	task automatic ackv(input int dly, input logic [7:0] e);
		logic ok;
		int   p0;
		p0 = n_pulse;
		i_cpu.ack(dly, d, ok);
		`CHK(ok, 1'b1)
		`CHK(d, e)
		`CHK(n_pulse - p0, 2)
	endtask

	// slave path reaches the output in three cycles; six is ample
	task automatic irqc(input logic e);
		repeat (6) @(posedge sys_clk);
		#1 `CHK(processor_irq_out, e)
	endtask

	task automatic lines(input logic [15:0] v);
		@(posedge sys_clk);
		irq_in <= v;
	endtask

	initial
	begin
		repeat (20000) @(posedge sys_clk);
		n_errors++;
		stop_test();
	end

	initial
	begin
		nrst = 1'b0;
		addr = 16'h0000;
		wr_data = 8'h00;
		wr_en = 1'b0;
		rd_en = 1'b0;
		irq_in = 16'h0000;
		repeat (10) @(posedge sys_clk);
		nrst <= 1'b1;
		// reset state, refused trigger bits, unmapped place
		irqc(1'b0);
		rdchk(LPIC_M_DATA_ADDR, 8'h00);
		wr(LPIC_M_TRIG_ADDR, 8'hff);
		rdchk(LPIC_M_TRIG_ADDR, 8'hf8);
		wr(LPIC_S_TRIG_ADDR, 8'hff);
		rdchk(LPIC_S_TRIG_ADDR, 8'hde);
		wr(LPIC_M_TRIG_ADDR, 8'h00);
		wr(LPIC_S_TRIG_ADDR, 8'h00);
		wr(16'h0022, 8'h5a);
		rdchk(16'h0022, 8'h00);
		init(MC, 8'h11, 8'h08, 8'h01);
		init(SC, 8'h11, 8'h70, 8'h01);
		// nesting, specific and plain end commands
		lines(16'h0028);
		irqc(1'b1);
		ackv(0, 8'h0b);
		irqc(1'b0);
		lines(16'h002a);
		irqc(1'b1);
		ackv(3, 8'h09);
		st(MC, 8'h0b, 8'h0a);
		wr(MC, 8'h20);
		st(MC, 8'h0b, 8'h08);
		wr(MC, 8'h63);
		st(MC, 8'h0b, 8'h00);
		ackv(0, 8'h0d);
		wr(MC, 8'h20);
		irqc(1'b0);
		st(MC, 8'h0a, 8'h00);
		lines(16'h0000);
		// level trigger; the requester drops before the end command
		wr(LPIC_M_TRIG_ADDR, 8'h08);
		lines(16'h0008);
		irqc(1'b1);
		ackv(0, 8'h0b);
		lines(16'h0000);
		wr(MC, 8'h20);
		irqc(1'b0);
		lines(16'h0008);
		irqc(1'b1);
		lines(16'h0000);
		ackv(0, 8'h0f);
		wr(LPIC_M_TRIG_ADDR, 8'h00);
		// cascade in plain nested mode
		lines(16'h1000);
		irqc(1'b1);
		ackv(0, 8'h74);
		`CHK(cascade_code, LPIC_CASCADE_ID)
		lines(16'h1200);
		irqc(1'b0);
		wr(SC, 8'h20);
		wr(MC, 8'h20);
		irqc(1'b1);
		ackv(2, 8'h71);
		wr(SC, 8'h20);
		wr(MC, 8'h20);
		lines(16'h0000);
		// special fully nested master
		init(MC, 8'h11, 8'h08, 8'h11);
		lines(16'h1000);
		ackv(0, 8'h74);
		lines(16'h1200);
		irqc(1'b1);
		ackv(0, 8'h71);
		wr(SC, 8'h20);
		st(SC, 8'h0b, 8'h10);
		wr(SC, 8'h20);
		st(SC, 8'h0b, 8'h00);
		wr(MC, 8'h20);
		st(MC, 8'h0b, 8'h00);
		lines(16'h0000);
		// rotation commands
		init(MC, 8'h11, 8'h08, 8'h01);
		lines(16'h0028);
		ackv(0, 8'h0b);
		wr(MC, 8'ha0);
		lines(16'h002a);
		ackv(0, 8'h0d);
		wr(MC, 8'hc6);
		lines(16'h00aa);
		ackv(0, 8'h0f);
		wr(MC, 8'he7);
		st(MC, 8'h0b, 8'h20);
		ackv(0, 8'h09);
		wr(MC, 8'h20);
		wr(MC, 8'h20);
		st(MC, 8'h0b, 8'h00);
		lines(16'h0000);
		// automatic end, controller-wide trigger bit set but ignored
		init(MC, 8'h19, 8'h08, 8'h03);
		lines(16'h0048);
		ackv(0, 8'h0b);
		st(MC, 8'h0b, 8'h00);
		ackv(0, 8'h0e);
		irqc(1'b0);
		wr(MC, 8'h80);
		lines(16'h0000);
		lines(16'h0041);
		ackv(0, 8'h08);
		lines(16'h0040);
		lines(16'h0041);
		ackv(0, 8'h0e);
		wr(MC, 8'h00);
		lines(16'h0000);
		// masking and special mask mode
		init(MC, 8'h11, 8'h08, 8'h01);
		lines(16'h0008);
		ackv(0, 8'h0b);
		wr(LPIC_M_DATA_ADDR, 8'h18);
		lines(16'h0018);
		irqc(1'b0);
		st(MC, 8'h0a, 8'h10);
		wr(MC, 8'h68);
		wr(MC, 8'h20);
		st(MC, 8'h0b, 8'h08);
		wr(MC, 8'h48);
		wr(MC, 8'h20);
		st(MC, 8'h0b, 8'h00);
		wr(LPIC_M_DATA_ADDR, 8'h00);
		ackv(0, 8'h0c);
		wr(MC, 8'h20);
		lines(16'h0000);
		// poll: request state frozen between the word and the read
		lines(16'h0020);
		wr(MC, 8'h0c);
		lines(16'h0022);
		rdchk(MC, 8'h85);
		st(MC, 8'h0b, 8'h20);
		stop_test();
	end
endmodule
